/* File: ufb_pkg.sv */
package ufb_pkg;

    localparam int UFB_CHANNELS = 4;
    localparam int UFB_FIFO_DEPTH = 64;
    localparam int UFB_ADDR_W = 11;
    localparam int UFB_CH_LSB = 9;
    localparam int UFB_BURST_BIT = 8;
    localparam int UFB_PAIR_BIT = 7;
    localparam int UFB_WIN_HI = 7;
    localparam int UFB_WIN_LO = 6;
    localparam logic [1:0] UFB_WIN_DATA = 2'h0;
    localparam logic [8:0] UFB_LEGACY_OFS = 9'h000;
    localparam logic [3:0] UFB_LEGACY_BE = 4'h1;
    localparam logic [7:0] UFB_EMPTY_BYTE = 8'h00;
    localparam logic [31:0] UFB_RDATA_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        UFB_KIND_NONE,
        UFB_KIND_BYTES,
        UFB_KIND_PAIRS
    } ufb_kind_t;

    typedef struct packed {
        logic write;
        logic [UFB_ADDR_W-1:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } ufb_req_t;

    typedef struct packed {
        logic [7:0] line_status_byte;
        logic [7:0] data;
    } ufb_rx_t;

    localparam ufb_req_t UFB_REQ_RST = '0;
    localparam ufb_rx_t UFB_RX_RST = '0;

endpackage : ufb_pkg

/* File: ufb_fifo.sv */
`timescale 1ns/1ps
module ufb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    output logic full,
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic empty,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] wr_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_rd_ptr;
    logic [AW-1:0] next_wr_ptr;
    logic [AW:0] next_count;
    logic do_push;
    logic do_pop;

    assign full = (count == (AW + 1)'(DEPTH));
    assign empty = (count == '0);
    assign head = mem[rd_ptr];
    assign level = count;

    // a push into a full fifo is dropped, like a uart overrun
    always_comb begin
        do_push = push && !full;
        do_pop = pop && !empty;
        next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= '0;
        end else begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count <= next_count;
        end
    end

    // storage has no reset; only slots behind the pointers are ever read
    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

endmodule : ufb_fifo

/* File: ufb_access.sv */
`timescale 1ns/1ps
//
// Overview of operation
// - per-channel window takes 8/16/24/32-bit accesses
// - burst writes and plain reads move up to 64 bytes, paired reads up to 128
// - 0xM80-0xMFF returns rx data with status bytes
// - plain rx burst of 16 doublewords
// - lane 0 oldest byte, lanes up in order
// - paired rx burst of 32 doublewords
// - lane0 status, lane1 data, lanes 2-3 next
// - tx burst of 16 doublewords fills fifo
// - tx lane 0 queued first, then 1,2,3
// - legacy byte register pops rx, pushes tx
// - legacy register byte-only, data without status
// - one logic clock drives the whole block
module ufb_access
    import ufb_pkg::*;
#(
    parameter int DEPTH = UFB_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic req_valid,
    input wire ufb_req_t req,
    output logic req_ready,
    output logic resp_valid,
    output logic [31:0] resp_rdata,
    input wire logic [UFB_CHANNELS-1:0] rx_valid,
    input wire ufb_rx_t [UFB_CHANNELS-1:0] rx_in,
    output logic [UFB_CHANNELS-1:0] rx_ready,
    output logic [UFB_CHANNELS-1:0] tx_valid,
    output logic [UFB_CHANNELS-1:0][7:0] tx_byte,
    input wire logic [UFB_CHANNELS-1:0] tx_ready,
    output logic [UFB_CHANNELS-1:0][$clog2(DEPTH):0] rx_level,
    output logic [UFB_CHANNELS-1:0][$clog2(DEPTH):0] tx_level
);
    typedef enum logic [1:0] {
        UFB_IDLE,
        UFB_LANE,
        UFB_RESP
    } ufb_state_t;

    function automatic ufb_kind_t ufb_decode(input logic [UFB_ADDR_W-1:0] a, input logic [3:0] be);
        ufb_kind_t k;
        k = UFB_KIND_NONE;
        if (a[UFB_BURST_BIT]) begin
            if (a[UFB_PAIR_BIT]) begin
                k = UFB_KIND_PAIRS;
            end else if (a[UFB_WIN_HI:UFB_WIN_LO] == UFB_WIN_DATA) begin
                k = UFB_KIND_BYTES;
            end
        end else if (a[UFB_BURST_BIT:0] == UFB_LEGACY_OFS && be == UFB_LEGACY_BE) begin
            k = UFB_KIND_BYTES;
        end
        return k;
    endfunction : ufb_decode

    ufb_state_t state;
    ufb_state_t next_state;
    ufb_req_t cur;
    ufb_req_t next_cur;
    ufb_kind_t kind;
    ufb_kind_t next_kind;
    logic [1:0] lane;
    logic [1:0] next_lane;
    logic [31:0] acc;
    logic [31:0] next_acc;
    ufb_rx_t hold;
    ufb_rx_t next_hold;
    logic next_resp_valid;

    logic [1:0] ch;
    logic pop_sel;
    logic push_sel;
    logic [7:0] push_byte;
    logic [7:0] lane_byte;
    logic lane_en;
    logic pair_en;

    logic [UFB_CHANNELS-1:0] rx_full;
    logic [UFB_CHANNELS-1:0] rx_empty;
    logic [UFB_CHANNELS-1:0] tx_full;
    logic [UFB_CHANNELS-1:0] tx_empty;
    ufb_rx_t [UFB_CHANNELS-1:0] rx_head;
    logic [UFB_CHANNELS-1:0][7:0] tx_head;

    assign ch = cur.addr[UFB_ADDR_W-1:UFB_CH_LSB];
    assign req_ready = (state == UFB_IDLE);

    // rx fifo filled by the receiver, tx fifo drained by the transmitter
    genvar gi;
    generate
        for (gi = 0; gi < UFB_CHANNELS; gi++) begin : g_ch
            ufb_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_rx (
                .mclk(mclk),
                .rst(rst),
                .push(rx_valid[gi]),
                .push_data(rx_in[gi]),
                .full(rx_full[gi]),
                .pop(pop_sel && ch == 2'(gi)),
                .head(rx_head[gi]),
                .empty(rx_empty[gi]),
                .level(rx_level[gi])
            );
            ufb_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx (
                .mclk(mclk),
                .rst(rst),
                .push(push_sel && ch == 2'(gi)),
                .push_data(push_byte),
                .full(tx_full[gi]),
                .pop(tx_ready[gi]),
                .head(tx_head[gi]),
                .empty(tx_empty[gi]),
                .level(tx_level[gi])
            );
            assign rx_ready[gi] = !rx_full[gi];
            assign tx_valid[gi] = !tx_empty[gi];
            assign tx_byte[gi] = tx_head[gi];
        end
    endgenerate

    // one lane per cycle, lane 0 first, so fifo order follows lane order
    always_comb begin
        lane_en = cur.be[lane];
        pair_en = cur.be[{lane[1], 1'b0}] || cur.be[{lane[1], 1'b1}];
        pop_sel = 1'b0;
        push_sel = 1'b0;
        push_byte = cur.wdata[8*lane +: 8];
        lane_byte = UFB_EMPTY_BYTE;
        next_hold = hold;
        if (state == UFB_LANE) begin
            unique case (kind)
                UFB_KIND_BYTES: begin
                    if (cur.write) begin
                        push_sel = lane_en;
                    end else if (lane_en && !rx_empty[ch]) begin
                        pop_sel = 1'b1;
                        lane_byte = rx_head[ch].data;
                    end
                end
                UFB_KIND_PAIRS: begin
                    // the host is expected to fetch a status/data pair in one access
                    if (!cur.write) begin
                        if (!lane[0]) begin
                            next_hold = UFB_RX_RST;
                            if (pair_en && !rx_empty[ch]) begin
                                pop_sel = 1'b1;
                                next_hold = rx_head[ch];
                            end
                            lane_byte = lane_en ? next_hold.line_status_byte : UFB_EMPTY_BYTE;
                        end else begin
                            lane_byte = lane_en ? hold.data : UFB_EMPTY_BYTE;
                        end
                    end
                end
                UFB_KIND_NONE: begin
                    lane_byte = UFB_EMPTY_BYTE;
                end
            endcase
        end
    end

    // every doubleword of a burst is a fresh request; no burst length limit of our own
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_kind = kind;
        next_lane = lane;
        next_acc = acc;
        next_resp_valid = 1'b0;
        unique case (state)
            UFB_IDLE: begin
                if (req_valid) begin
                    next_state = UFB_LANE;
                    next_cur = req;
                    next_kind = ufb_decode(req.addr, req.be);
                    next_lane = 2'h0;
                    next_acc = UFB_RDATA_RST;
                end
            end
            UFB_LANE: begin
                next_acc[8*lane +: 8] = lane_byte;
                next_lane = lane + 2'h1;
                if (lane == 2'h3) begin
                    next_state = UFB_RESP;
                    next_resp_valid = 1'b1;
                end
            end
            UFB_RESP: begin
                next_state = UFB_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= UFB_IDLE;
            cur <= UFB_REQ_RST;
            kind <= UFB_KIND_NONE;
            lane <= 2'h0;
            acc <= UFB_RDATA_RST;
            hold <= UFB_RX_RST;
            resp_valid <= 1'b0;
            resp_rdata <= UFB_RDATA_RST;
        end else begin
            state <= next_state;
            cur <= next_cur;
            kind <= next_kind;
            lane <= next_lane;
            acc <= next_acc;
            hold <= next_hold;
            resp_valid <= next_resp_valid;
            resp_rdata <= next_resp_valid ? next_acc : resp_rdata;
        end
    end

endmodule : ufb_access

/* File: ufb_access_checker.sv */
`timescale 1ns/1ps
module ufb_access_checker
    import ufb_pkg::*;
#(
    parameter int DEPTH = UFB_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire logic [31:0] resp_rdata,
    input wire logic [UFB_CHANNELS-1:0] rx_valid,
    input wire logic [UFB_CHANNELS-1:0] rx_ready,
    input wire logic [UFB_CHANNELS-1:0] tx_valid,
    input wire logic [UFB_CHANNELS-1:0] tx_ready,
    input wire logic [UFB_CHANNELS-1:0][$clog2(DEPTH):0] rx_level,
    input wire logic [UFB_CHANNELS-1:0][$clog2(DEPTH):0] tx_level
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // idle gate keeps host pops and pushes out of the level arithmetic
    wire idle = req_ready && !req_valid;
    sequence s_busy;
        !req_ready [*4] ##1 (!req_ready && resp_valid) ##1 (req_ready && !resp_valid);
    endsequence
    a_fixed_latency: assert property (req_valid && req_ready |=> s_busy)
        else $error("access latency wrong");
    a_resp_pulse: assert property (resp_valid |=> !resp_valid)
        else $error("response longer than one cycle");
    a_rdata_hold: assert property (!resp_valid |-> $stable(resp_rdata))
        else $error("read data moved without response");
    a_rx_ready_full: assert property (rx_ready[1] == (rx_level[1] != DEPTH))
        else $error("rx ready not tied to fill");
    a_tx_valid_fill: assert property (tx_valid[3] == (tx_level[3] != 0))
        else $error("tx valid not tied to fill");
    a_rx_push_count: assert property (rx_valid[1] && rx_ready[1] && idle |=> rx_level[1] == $past(rx_level[1]) + 1)
        else $error("rx push not counted");
    a_tx_pop_count: assert property (tx_valid[3] && tx_ready[3] && idle |=> tx_level[3] == $past(tx_level[3]) - 1)
        else $error("tx pop not counted");
    a_tx_no_wrap: assert property (tx_level[3] == DEPTH && !tx_ready[3] |=> tx_level[3] == DEPTH)
        else $error("tx fifo passed full");
endmodule : ufb_access_checker
bind ufb_access ufb_access_checker #(.DEPTH(DEPTH)) i_chk (.mclk, .rst, .req_valid, .req_ready, .resp_valid,
    .resp_rdata, .rx_valid, .rx_ready, .tx_valid, .tx_ready, .rx_level, .tx_level);

/* File: ufb_uart_model.sv */
`timescale 1ns/1ps
module ufb_uart_model
    import ufb_pkg::*;
(
    input wire logic mclk,
    input wire logic tx_stall,
    input wire logic [3:0] tx_valid,
    input wire logic [3:0][7:0] tx_byte,
    output logic [3:0] tx_ready,
    output logic [3:0] rx_valid,
    output ufb_rx_t [3:0] rx_in
);
    logic [7:0] got[4][$];
    assign tx_ready = tx_stall ? 4'h0 : 4'hF;
    initial begin
        rx_valid = 4'h0;
        rx_in = '0;
    end
    always @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            if (tx_valid[i] && tx_ready[i]) got[i].push_back(tx_byte[i]);
        end
    end
    // released lines show the inverse so stale data never looks valid
    task automatic send(input int ch, input ufb_rx_t v);
        @(negedge mclk);
        rx_in[ch] = v;
        rx_valid[ch] = 1'b1;
        @(negedge mclk);
        rx_valid[ch] = 1'b0;
        rx_in[ch] = ~v;
    endtask : send
endmodule : ufb_uart_model

/* File: tb_uart_fifo_burst_access.sv */
`timescale 1ns/1ps
module tb_uart_fifo_burst_access;
    import ufb_pkg::*;
    logic mclk = 0, rst = 1, req_valid = 0, req_ready, resp_valid, tx_stall = 1;
    ufb_req_t req = UFB_REQ_RST;
    logic [31:0] resp_rdata, rd;
    logic [3:0] rx_valid, rx_ready, tx_valid, tx_ready;
    ufb_rx_t [3:0] rx_in;
    logic [3:0][7:0] tx_byte;
    logic [3:0][6:0] rx_level, tx_level;
    int err_count = 0, samples_checked = 0;
    always #20 mclk = ~mclk;
    ufb_access #(.DEPTH(64)) i_dut (.mclk, .rst, .req_valid, .req, .req_ready, .resp_valid, .resp_rdata,
        .rx_valid, .rx_in, .rx_ready, .tx_valid, .tx_byte, .tx_ready, .rx_level, .tx_level);
    ufb_uart_model i_uart (.mclk, .tx_stall, .tx_valid, .tx_byte, .tx_ready, .rx_valid, .rx_in);
    task automatic conclude();
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [10:0] a, input logic [3:0] be, input logic [31:0] d);
        int n;
        @(negedge mclk);
        req = '{write: w, addr: a, be: be, wdata: d};
        req_valid = 1;
        @(negedge mclk);
        req_valid = 0;
        for (n = 0; n < 20 && resp_valid !== 1'b1; n++) @(negedge mclk);
        chk("latency", 4, n);
        if (n == 20) conclude();
        rd = resp_rdata;
    endtask : acc
    task automatic t_plain();
        for (int i = 0; i < 8; i++) i_uart.send(1, {8'h00, 8'(8'hA0 + i)});
        acc(0, 11'h300, 4'hF, 0);
        chk("rx dword", 32'hA3A2A1A0, rd);
        acc(0, 11'h304, 4'h6, 0);
        chk("rx lanes", 32'h00A5A400, rd & 32'h00FFFF00);
        chk("rx level", 2, rx_level[1]);
        acc(0, 11'h340, 4'hF, 0);
        chk("unmapped", 0, rd);
        acc(0, 11'h308, 4'hF, 0);
        chk("rx tail", 32'h0000A7A6, rd);
    endtask : t_plain
    task automatic t_pair();
        i_uart.send(2, 16'h1155);
        i_uart.send(2, 16'h2266);
        acc(0, 11'h580, 4'hF, 0);
        chk("pair", 32'h66225511, rd);
    endtask : t_pair
    task automatic t_tx();
        int n;
        for (int k = 0; k < 17; k++) begin
            acc(1, 11'(11'h700 + 4 * (k % 16)), 4'hF, {8'(4*k+3), 8'(4*k+2), 8'(4*k+1), 8'(4*k)});
        end
        chk("tx full", 64, tx_level[3]);
        tx_stall = 0;
        for (n = 0; n < 200 && tx_level[3] != 0; n++) @(negedge mclk);
        if (n == 200) begin
            chk("tx drain timeout", 0, 1);
            conclude();
        end
        chk("tx count", 64, i_uart.got[3].size());
        for (int j = 0; j < 64; j++) chk("tx order", j, i_uart.got[3][j]);
    endtask : t_tx
    task automatic t_legacy();
        for (int c = 0; c < 4; c++) begin
            i_uart.send(c, {8'h5A, 8'(8'hC0 + c)});
            acc(0, 11'(c * 12'h200), 4'h3, 0);
            chk("legacy wide", 0, rd);
            acc(0, 11'(c * 12'h200), 4'h1, 0);
            chk("legacy rx", 8'hC0 + c, rd);
            acc(1, 11'(c * 12'h200), 4'h1, {24'h0, 8'(8'hE0 + c)});
            chk("legacy wr rdata", 0, rd);
            chk("legacy tx", 8'hE0 + c, i_uart.got[c][$]);
        end
    endtask : t_legacy
    initial begin
        repeat (4) @(negedge mclk);
        rst = 0;
        t_plain();
        t_pair();
        t_tx();
        t_legacy();
        conclude();
    end
endmodule : tb_uart_fifo_burst_access
